// ==== pdcb_bank.sv ====
// Divider configuration bank for two synthesizers
//
// Overview of operation
// - Synth 1 reference divider: bits 2..0, zero bypasses, n divides by n+1, reset 0.
// - Synth 1 feedback divider: bits 4..0, zero bypasses, n divides by n+1, reset 0.
// - Synth 2 reference divider: bits 2..0, zero bypasses, n divides by n+1, reset 0.
// - Synth 2 feedback divider: bits 4..0, zero bypasses, n divides by n+1, reset 0.
// - Synth 1 post-divider code at bits 4..2, reset 7; codes 0,1 give 2, 2 gives 3.
//
// Strobed register access is this design's own decision.
`include "pdcb_defs.svh"

module pdcb_bank (
   input  wire logic                          i_sys_clk,
   input  wire logic                          i_srst,
   input  wire pdcb_pkg::pdcb_bus_type        i_bus,
   output logic [`PDCB_DATA_W-1:0]            o_rdata,
   output logic                               o_rvalid,
   output pdcb_pkg::pdcb_ref_type             o_synth1_ref,
   output pdcb_pkg::pdcb_fb_type              o_synth1_fb,
   output pdcb_pkg::pdcb_ref_type             o_synth2_ref,
   output pdcb_pkg::pdcb_fb_type              o_synth2_fb,
   output logic [`PDCB_POST_RATIO_W-1:0]      o_synth1_post
);
   import pdcb_pkg::*;

   // ***************************************************************
   // Register storage
   // ***************************************************************
   logic [`PDCB_REF_W-1:0]   synth1_ref_ratio_r;
   logic [`PDCB_FB_W-1:0]    synth1_fb_ratio_r;
   logic [`PDCB_REF_W-1:0]   synth2_ref_ratio_r;
   logic [`PDCB_FB_W-1:0]    synth2_fb_ratio_r;
   logic [`PDCB_POST_W-1:0]  synth1_post_ratio_r;
   logic [`PDCB_DATA_W-1:0]  rdata_nxt;
   logic [`PDCB_DATA_W-1:0]  rdata_r;
   logic                     rvalid_r;
   logic                     wr_s1_ref;
   logic                     wr_s1_fb;
   logic                     wr_s2_ref;
   logic                     wr_s2_fb;
   logic                     wr_s1_ctrl;
   logic [`PDCB_REF_W-1:0]   synth1_ref_ratio_nxt;
   logic [`PDCB_FB_W-1:0]    synth1_fb_ratio_nxt;
   logic [`PDCB_REF_W-1:0]   synth2_ref_ratio_nxt;
   logic [`PDCB_FB_W-1:0]    synth2_fb_ratio_nxt;
   logic [`PDCB_POST_W-1:0]  synth1_post_ratio_nxt;
   pdcb_ref_type             synth1_ref_nxt;
   pdcb_ref_type             synth1_ref_r;
   pdcb_fb_type              synth1_fb_nxt;
   pdcb_fb_type              synth1_fb_r;
   pdcb_ref_type             synth2_ref_nxt;
   pdcb_ref_type             synth2_ref_r;
   pdcb_fb_type              synth2_fb_nxt;
   pdcb_fb_type              synth2_fb_r;
   logic [`PDCB_POST_RATIO_W-1:0] synth1_post_nxt;
   logic [`PDCB_POST_RATIO_W-1:0] synth1_post_r;

   // ***************************************************************
   // Write decode: one strobe per mapped register
   // ***************************************************************
   assign wr_s1_ref  = i_bus.wr && (i_bus.addr == `PDCB_OFS_S1_REF);
   assign wr_s1_fb   = i_bus.wr && (i_bus.addr == `PDCB_OFS_S1_FB);
   assign wr_s2_ref  = i_bus.wr && (i_bus.addr == `PDCB_OFS_S2_REF);
   assign wr_s2_fb   = i_bus.wr && (i_bus.addr == `PDCB_OFS_S2_FB);
   assign wr_s1_ctrl = i_bus.wr && (i_bus.addr == `PDCB_OFS_S1_CTRL);

   // ***************************************************************
   // Next field codes
   // ***************************************************************
   // Reset is synchronous, so it folds into the next-value select: the code
   // register and its registered decode load from one source and never
   // disagree for a cycle. Reserved bits are not stored at all.
   always_comb
   begin
      synth1_ref_ratio_nxt = synth1_ref_ratio_r;
      if (i_srst)
         synth1_ref_ratio_nxt = `PDCB_RST_REF;
      else if (wr_s1_ref)
         synth1_ref_ratio_nxt = i_bus.wdata[`PDCB_REF_W-1:`PDCB_REF_LSB];
   end

   always_comb
   begin
      synth1_fb_ratio_nxt = synth1_fb_ratio_r;
      if (i_srst)
         synth1_fb_ratio_nxt = `PDCB_RST_FB;
      else if (wr_s1_fb)
         synth1_fb_ratio_nxt = i_bus.wdata[`PDCB_FB_W-1:`PDCB_FB_LSB];
   end

   always_comb
   begin
      synth2_ref_ratio_nxt = synth2_ref_ratio_r;
      if (i_srst)
         synth2_ref_ratio_nxt = `PDCB_RST_REF;
      else if (wr_s2_ref)
         synth2_ref_ratio_nxt = i_bus.wdata[`PDCB_REF_W-1:`PDCB_REF_LSB];
   end

   always_comb
   begin
      synth2_fb_ratio_nxt = synth2_fb_ratio_r;
      if (i_srst)
         synth2_fb_ratio_nxt = `PDCB_RST_FB;
      else if (wr_s2_fb)
         synth2_fb_ratio_nxt = i_bus.wdata[`PDCB_FB_W-1:`PDCB_FB_LSB];
   end

   // Control bits 1..0 are not kept here; only the post-divider code is
   always_comb
   begin
      synth1_post_ratio_nxt = synth1_post_ratio_r;
      if (i_srst)
         synth1_post_ratio_nxt = `PDCB_RST_POST;
      else if (wr_s1_ctrl)
         synth1_post_ratio_nxt = i_bus.wdata[`PDCB_POST_MSB:`PDCB_POST_LSB];
   end

   // ***************************************************************
   // Read path: data one cycle after the strobe, zeros elsewhere
   // ***************************************************************
   always_comb
   begin
      rdata_nxt = '0;
      // Reserved and unmapped bits read as zero; software must not rely on them
      unique case (i_bus.addr)
         `PDCB_OFS_S1_REF:  rdata_nxt[`PDCB_REF_W-1:0] = synth1_ref_ratio_r;
         `PDCB_OFS_S1_FB:   rdata_nxt[`PDCB_FB_W-1:0]  = synth1_fb_ratio_r;
         `PDCB_OFS_S2_REF:  rdata_nxt[`PDCB_REF_W-1:0] = synth2_ref_ratio_r;
         `PDCB_OFS_S2_FB:   rdata_nxt[`PDCB_FB_W-1:0]  = synth2_fb_ratio_r;
         `PDCB_OFS_S1_CTRL: rdata_nxt[`PDCB_POST_MSB:`PDCB_POST_LSB] = synth1_post_ratio_r;
         default:           rdata_nxt = '0;
      endcase
   end

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         rdata_r  <= '0;
         rvalid_r <= 1'b0;
      end
      else
      begin
         rdata_r  <= i_bus.rd ? rdata_nxt : '0;
         rvalid_r <= i_bus.rd;
      end
   end

   assign o_rdata  = rdata_r;
   assign o_rvalid = rvalid_r;

   // ***************************************************************
   // Ratio decode
   // ***************************************************************
   pdcb_ratio_decode #(.CODE_W(`PDCB_REF_W), .RATIO_W(`PDCB_REF_RATIO_W)) u_s1_ref (
      .i_code   (synth1_ref_ratio_nxt),
      .o_bypass (synth1_ref_nxt.bypass),
      .o_ratio  (synth1_ref_nxt.ratio)
   );

   pdcb_ratio_decode #(.CODE_W(`PDCB_FB_W), .RATIO_W(`PDCB_FB_RATIO_W)) u_s1_fb (
      .i_code   (synth1_fb_ratio_nxt),
      .o_bypass (synth1_fb_nxt.bypass),
      .o_ratio  (synth1_fb_nxt.ratio)
   );

   pdcb_ratio_decode #(.CODE_W(`PDCB_REF_W), .RATIO_W(`PDCB_REF_RATIO_W)) u_s2_ref (
      .i_code   (synth2_ref_ratio_nxt),
      .o_bypass (synth2_ref_nxt.bypass),
      .o_ratio  (synth2_ref_nxt.ratio)
   );

   pdcb_ratio_decode #(.CODE_W(`PDCB_FB_W), .RATIO_W(`PDCB_FB_RATIO_W)) u_s2_fb (
      .i_code   (synth2_fb_ratio_nxt),
      .o_bypass (synth2_fb_nxt.bypass),
      .o_ratio  (synth2_fb_nxt.ratio)
   );

   // Codes 0 and 1 both give 2; codes above 2 are assumed to continue as n+1
   always_comb
   begin
      if (synth1_post_ratio_nxt <= `PDCB_POST_W'(1))
         synth1_post_nxt = `PDCB_POST_RATIO_W'(2);
      else
         synth1_post_nxt = `PDCB_POST_RATIO_W'(synth1_post_ratio_nxt)
                           + `PDCB_POST_RATIO_W'(1);
   end

   // ***************************************************************
   // Field registers: code for readback, ratio for the synthesizer
   // ***************************************************************
   // The ratio is decoded from the next code and stored beside it, so the
   // synthesizer sees flop outputs at no extra cycle of latency
   always_ff @(posedge i_sys_clk)
   begin
      synth1_ref_ratio_r <= synth1_ref_ratio_nxt;
      synth1_ref_r       <= synth1_ref_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      synth1_fb_ratio_r <= synth1_fb_ratio_nxt;
      synth1_fb_r       <= synth1_fb_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      synth2_ref_ratio_r <= synth2_ref_ratio_nxt;
      synth2_ref_r       <= synth2_ref_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      synth2_fb_ratio_r <= synth2_fb_ratio_nxt;
      synth2_fb_r       <= synth2_fb_nxt;
   end

   always_ff @(posedge i_sys_clk)
   begin
      synth1_post_ratio_r <= synth1_post_ratio_nxt;
      synth1_post_r       <= synth1_post_nxt;
   end

   assign o_synth1_ref  = synth1_ref_r;
   assign o_synth1_fb   = synth1_fb_r;
   assign o_synth2_ref  = synth2_ref_r;
   assign o_synth2_fb   = synth2_fb_r;
   assign o_synth1_post = synth1_post_r;
endmodule

// ==== pdcb_bank_bench.sv ====
// Self-checking bench for the divider bank
module pdcb_bank_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import pdcb_pkg::*;
   logic i_sys_clk = 1'b0;
   logic i_srst = 1'b1;
   pdcb_bus_type i_bus = '0;
   logic [7:0] o_rdata;
   logic o_rvalid;
   logic [3:0] o_synth1_post;
   pdcb_ref_type o_synth1_ref, o_synth2_ref;
   pdcb_fb_type o_synth1_fb, o_synth2_fb;
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   pdcb_bank i_pdcb_bank (.i_sys_clk, .i_srst, .i_bus, .o_rdata, .o_rvalid, .o_synth1_ref,
      .o_synth1_fb, .o_synth2_ref, .o_synth2_fb, .o_synth1_post);
   initial forever #2 i_sys_clk = ~i_sys_clk;
   always @(posedge i_sys_clk)
   begin
      cycles++;
      if (cycles == 4000) // About six times the planned run
      begin
         mismatches++;
         print_verdict();
      end
   end
   function automatic logic [7:0] rf(input logic [4:0] c);
      return {c == 5'h0, c == 5'h0 ? 7'h1 : 7'(c) + 7'h1};
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      if (got !== exp) mismatches++;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_bus.addr <= a;
      i_bus.wdata <= d;
      i_bus.wr <= 1'b1;
      @(posedge i_sys_clk);
      i_bus.wr <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge i_sys_clk);
      i_bus.addr <= a;
      i_bus.rd <= 1'b1;
      @(posedge i_sys_clk);
      i_bus.rd <= 1'b0;
      #1;
      chk(o_rdata, e);
      chk({7'h0, o_rvalid}, 8'h01);
   endtask
   task outs(input logic [4:0] c, input logic [3:0] p);
      chk({o_synth1_ref.bypass, 3'h0, o_synth1_ref.ratio}, rf(c[2:0]));
      chk({o_synth1_fb.bypass, 1'h0, o_synth1_fb.ratio}, rf(c));
      chk({o_synth2_ref.bypass, 3'h0, o_synth2_ref.ratio}, rf(c[2:0]));
      chk({o_synth2_fb.bypass, 1'h0, o_synth2_fb.ratio}, rf(c));
      chk({4'h0, o_synth1_post}, {4'h0, p});
   endtask
   task print_verdict();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      #1;
      outs(5'h0, 4'h8);
      rd(8'h38, 8'h1C);
      $display("reset values done");
      // Reserved upper bits go out as zero; unkept control bits 1..0 read back as zero
      for (int c = 0; c < 32; c++)
      begin
         for (int r = 0; r < 4; r++) wr(8'h34 + 8'(r), r % 2 ? 8'(c) : 8'(c % 8));
         wr(8'h38, {3'h0, 3'(c), 2'h3});
         outs(5'(c), c % 8 < 2 ? 4'h2 : 4'(c % 8) + 4'h1);
         rd(8'h34, 8'(c % 8));
         rd(8'h35, 8'(c));
         rd(8'h36, 8'(c % 8));
         rd(8'h37, 8'(c));
         rd(8'h38, 8'(c % 8) << 2);
      end
      $display("code sweep done");
      wr(8'h39, 8'hFF);
      rd(8'h39, 8'h00);
      wr(8'h38, 8'h08);
      chk({4'h0, o_synth1_post}, 8'h03);
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      @(posedge i_sys_clk);
      i_srst <= 1'b0;
      #1;
      outs(5'h0, 4'h8);
      rd(8'h38, 8'h1C);
      $display("unmapped and second reset done");
      print_verdict();
   end
endmodule
bind pdcb_bank pdcb_bank_checker i_pdcb_bank_checker (.i_sys_clk, .i_srst, .i_bus, .o_rdata,
   .o_rvalid, .o_synth1_ref, .o_synth1_fb, .o_synth2_ref, .o_synth2_fb, .o_synth1_post);

// ==== pdcb_bank_checker.sv ====
// Port assertions for the divider bank
module pdcb_bank_checker (
   input wire logic                   i_sys_clk,
   input wire logic                   i_srst,
   input wire pdcb_pkg::pdcb_bus_type i_bus,
   input wire logic [7:0]             o_rdata,
   input wire logic                   o_rvalid,
   input wire pdcb_pkg::pdcb_ref_type o_synth1_ref,
   input wire pdcb_pkg::pdcb_fb_type  o_synth1_fb,
   input wire pdcb_pkg::pdcb_ref_type o_synth2_ref,
   input wire pdcb_pkg::pdcb_fb_type  o_synth2_fb,
   input wire logic [3:0]             o_synth1_post
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   function automatic logic [7:0] rf(input logic [4:0] c);
      return {c == 5'h0, c == 5'h0 ? 7'h1 : 7'(c) + 7'h1};
   endfunction
   property p_s1r; i_bus.wr && i_bus.addr == 8'h34 |=>
      {o_synth1_ref.bypass, 3'h0, o_synth1_ref.ratio} == rf($past(i_bus.wdata[2:0])); endproperty
   a_s1r: assert property (p_s1r) else $error("synth1 ref wrong");
   property p_s1f; i_bus.wr && i_bus.addr == 8'h35 |=>
      {o_synth1_fb.bypass, 1'h0, o_synth1_fb.ratio} == rf($past(i_bus.wdata[4:0])); endproperty
   a_s1f: assert property (p_s1f) else $error("synth1 fb wrong");
   property p_s2r; i_bus.wr && i_bus.addr == 8'h36 |=>
      {o_synth2_ref.bypass, 3'h0, o_synth2_ref.ratio} == rf($past(i_bus.wdata[2:0])); endproperty
   a_s2r: assert property (p_s2r) else $error("synth2 ref wrong");
   property p_s2f; i_bus.wr && i_bus.addr == 8'h37 |=>
      {o_synth2_fb.bypass, 1'h0, o_synth2_fb.ratio} == rf($past(i_bus.wdata[4:0])); endproperty
   a_s2f: assert property (p_s2f) else $error("synth2 fb wrong");
   property p_post; i_bus.wr && i_bus.addr == 8'h38 |=> o_synth1_post ==
      ($past(i_bus.wdata[4:3]) == 2'h0 ? 4'h2 : 4'($past(i_bus.wdata[4:2])) + 4'h1); endproperty
   a_post: assert property (p_post) else $error("post ratio wrong");
   property p_rst; $past(i_srst) |-> o_synth1_post == 4'h8 && o_synth2_fb.bypass; endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_rdfb; i_bus.rd && i_bus.addr == 8'h35 |=>
      o_rvalid && o_rdata == {3'h0, $past(o_synth1_fb.ratio[4:0]) - 5'h1}; endproperty
   a_rdfb: assert property (p_rdfb) else $error("fb readback wrong");
   property p_idle; !o_rvalid |-> o_rdata == 8'h0; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   c_post: cover property (i_bus.wr && i_bus.addr == 8'h38);
   c_max: cover property (o_synth1_fb.ratio == 6'h20);
   c_gap: cover property (i_bus.rd && i_bus.addr == 8'h39);
endmodule

// ==== pdcb_defs.svh ====
// Register offsets, field positions, reset values and widths of the divider bank
`ifndef PDCB_DEFS_SVH
`define PDCB_DEFS_SVH

`define PDCB_ADDR_W          8
`define PDCB_DATA_W          8

`define PDCB_OFS_S1_REF      8'h34
`define PDCB_OFS_S1_FB       8'h35
`define PDCB_OFS_S2_REF      8'h36
`define PDCB_OFS_S2_FB       8'h37
`define PDCB_OFS_S1_CTRL     8'h38

`define PDCB_REF_W           3
`define PDCB_FB_W            5
`define PDCB_POST_W          3
`define PDCB_REF_LSB         0
`define PDCB_FB_LSB          0
`define PDCB_POST_LSB        2
`define PDCB_POST_MSB        4

`define PDCB_RST_REF         3'h0
`define PDCB_RST_FB          5'h00
`define PDCB_RST_POST        3'h7

// Ratio output widths: reference up to 8, feedback up to 32, post up to 8
`define PDCB_REF_RATIO_W     4
`define PDCB_FB_RATIO_W      6
`define PDCB_POST_RATIO_W    4

`endif

// ==== pdcb_pkg.sv ====
// Types shared by the divider configuration bank
package pdcb_pkg;
   typedef struct packed {
      logic       bypass;
      logic [3:0] ratio;
   } pdcb_ref_type;

   typedef struct packed {
      logic       bypass;
      logic [5:0] ratio;
   } pdcb_fb_type;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } pdcb_bus_type;
endpackage

// ==== pdcb_ratio_decode.sv ====
// Turns a divider code into bypass flag and divide ratio (code n divides by n+1)
module pdcb_ratio_decode #(
   parameter int CODE_W  = 3,
   parameter int RATIO_W = 4
) (
   input  wire logic [CODE_W-1:0]  i_code,
   output logic                    o_bypass,
   output logic [RATIO_W-1:0]      o_ratio
);
   // Bypass reports a ratio of one so downstream math stays uniform
   assign o_bypass = (i_code == '0);
   assign o_ratio  = o_bypass ? RATIO_W'(1) : RATIO_W'(i_code) + RATIO_W'(1);
endmodule
